// ==== dv/pic_core_model.sv ====
// pic_core_model: cpu core side of the interrupt handshake
// assumes bench clock and reset; acts on falling edges
`timescale 1ns/1ns
module pic_core_model (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic irq_request,
	input  wire logic slow,
	output logic      instr_last,
	output logic      accept_ack
);
	int cnt;
	// two-cycle instructions; a slow core answers late
	always @(negedge clock) begin
		accept_ack <= 1'b0;
		instr_last <= !instr_last && !sys_rst;
		if (sys_rst || !irq_request || accept_ack)
			cnt <= 0;
		else if (cnt == (slow ? 5 : 1)) begin
			accept_ack <= 1'b1; // single-cycle acknowledge
			cnt <= 0;
		end else
			cnt <= cnt + 1;
	end
endmodule

// ==== dv/pic_top_props.sv ====
// pic_top_props: port assertions for pic_top
// assumes only top-level ports; bound at the foot
`timescale 1ns/1ns
module pic_top_props
	import pic_pkg::*;
(
	input wire logic         clock,
	input wire logic         sys_rst,
	input wire pic_sfr_req_t sfr_req,
	input wire logic [7:0]   sfr_rdata,
	input wire logic         instr_last,
	input wire logic         accept_ack,
	input wire logic         irq_request,
	input wire logic [15:0]  irq_vector,
	input wire logic         accept_busy,
	input wire logic         nm_active
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// handshake with the core
	AST_ACK_DROP: assert property (irq_request && accept_ack |=> !irq_request)
		else $error("request kept after ack");
	AST_BUSY_RUN: assert property (irq_request && accept_ack |=> accept_busy[*7])
		else $error("sequence cut short");
	AST_SAMPLE: assert property ($rose(irq_request) |-> $past(instr_last))
		else $error("request off the sampling point");
	AST_VEC_RANGE: assert property (irq_request |-> irq_vector inside {[16'hffe0:16'hfffc]}
		&& !irq_vector[0]) else $error("bad vector");
	// pseudo non-maskable service
	AST_NM_SET: assert property (irq_request && accept_ack && irq_vector > 16'hfff8 |=> nm_active)
		else $error("service flag missing");
	AST_NM_NONEST: assert property (nm_active |-> !irq_request || irq_vector < 16'hfffa)
		else $error("nested pseudo service");
	// register reads
	AST_RD_HOLD: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata))
		else $error("read data moved");
	AST_UNMAPPED: assert property (sfr_req.rd && !(sfr_req.addr inside {[8'h3a:8'h3d]})
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind pic_top pic_top_props u_props (.*);

// ==== dv/pic_top_tb.sv ====
// pic_top_tb: self-checking bench for pic_top
// assumes the core model drives the handshake; bench drives the rest
`timescale 1ns/1ns
module pic_top_tb
	import pic_pkg::*;
;
	logic clock = 1'b0, sys_rst = 1'b1, software_trap = 1'b0, ext0_pin_gate = 1'b0;
	logic maskable_return = 1'b0, nonmaskable_return = 1'b0, slow = 1'b0, rd_q = 1'b0;
	logic instr_last, accept_ack, irq_request, accept_busy, nm_active;
	logic [7:0] sfr_rdata, er[$];
	logic [15:2] src_request = '0;
	logic [15:0] irq_vector, p, m, ev[$];
	pic_sfr_req_t sfr_req = '0;
	integer seed = 32'h0a65;
	int fail_count = 0, num_checks = 0, acks = 0, want = 0, cyc = 0, n;
	pic_top uut (.*);
	pic_core_model core (.*);
	always #5 clock = ~clock;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %h %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one byte access; a read notes the byte it expects
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (!w) er.push_back(d);
		sfr_req <= '{w, !w, a, d};
		@(negedge clock);
		sfr_req <= '0;
		@(negedge clock);
	endtask
	// waits for one acceptance, reads the enable byte, then returns
	task automatic svc(input logic nm, input logic [7:0] mid);
		want++;
		for (int i = 0; i < 80 && acks < want; i++) @(negedge clock);
		for (int i = 0; i < 20 && accept_busy; i++) @(negedge clock);
		software_trap <= nm; // must be ignored meanwhile
		sfr(1'b0, 8'h3a, mid);
		software_trap <= 1'b0;
		{maskable_return, nonmaskable_return} <= {!nm, nm};
		@(negedge clock);
		{maskable_return, nonmaskable_return} <= 2'b00;
	endtask
	// compares results as they appear; also cuts a hang short
	always @(posedge clock) begin
		rd_q <= sfr_req.rd;
		cyc++;
		if (rd_q)
			chk({8'h00, sfr_rdata}, {8'h00, er.pop_front()});
		if (irq_request && accept_ack) begin
			chk(irq_vector, ev.size() ? ev.pop_front() : 16'hxxxx);
			acks++;
		end
		if (cyc > 20000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(negedge clock);
		sys_rst <= 1'b0;
		ext0_pin_gate <= 1'b1;
		@(negedge clock);
		chk(irq_vector, 16'hfffe);
		for (int a = 'h3a; a < 'h3f; a++) sfr(1'b0, 8'(a), 8'h00);
		sfr(1'b1, 8'h3b, 8'hff);
		// random latch sets, masked clears, then service in priority order
		for (int r = 0; r < 8; r++) begin
			p = 16'($random(seed)) & 16'hfff8;
			m = 16'($random(seed)) | 16'h0004; // watchdog latch left alone
			slow <= p[4];
			src_request <= p[15:2];
			@(negedge clock);
			src_request <= '0;
			sfr(1'b1, 8'h3c, m[7:0]);
			sfr(1'b1, 8'h3d, m[15:8]);
			p = p & m;
			sfr(1'b0, 8'h3c, p[7:0]);
			sfr(1'b0, 8'h3d, p[15:8]);
			for (int i = 3; i < 16; i++) if (p[i]) ev.push_back(16'hfffe - 16'(2 * i));
			n = ev.size();
			sfr(1'b1, 8'h3a, 8'hff);
			repeat (n) svc(1'b0, 8'hf0);
			sfr(1'b0, 8'h3c, 8'h00);
			sfr(1'b0, 8'h3d, 8'h00);
			sfr(1'b1, 8'h3a, 8'h00);
		end
		// watchdog with the master flag set, then the trap with it clear
		for (int k = 0; k < 2; k++) begin
			sfr(1'b1, 8'h3a, k ? 8'h00 : 8'hff);
			ev.push_back(k ? 16'hfffc : 16'hfffa);
			src_request <= {13'h0000, !k[0]};
			software_trap <= k[0];
			repeat (2) @(negedge clock);
			{src_request, software_trap} <= '0;
			svc(1'b1, k ? 8'h00 : 8'hf0);
			sfr(1'b0, 8'h3a, k ? 8'h00 : 8'hf1);
		end
		chk(16'(ev.size()), 16'h0000);
		end_sim();
	end
endmodule

// ==== verilog/pic_params.svh ====
// pic_params.svh: constants for the prioritized interrupt controller
// assumes a byte-wide special-function register port driven by the cpu core
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_ADDR_ENABLE_LO  8'h3a
`define PIC_ADDR_ENABLE_HI  8'h3b
`define PIC_ADDR_PENDING_LO 8'h3c
`define PIC_ADDR_PENDING_HI 8'h3d
`define PIC_VECTOR_TOP      16'hfffe
`define PIC_MEF_BIT         0
`define PIC_SRC_TRAP        4'h1
`define PIC_SRC_WDT         4'h2
`define PIC_SRC_EXT0        4'h3
`define PIC_FIRST_GATED     4
`define PIC_ACCEPT_CYCLES   4'h8
`define PIC_ENABLE_RESET    16'h0000
`define PIC_PENDING_RESET   16'h0000
`endif

// ==== verilog/pic_pkg.sv ====
// pic_pkg: shared types for the prioritized interrupt controller
// assumes pic_params.svh is included where the constants are needed
package pic_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pic_sfr_req_t;
	typedef enum logic [2:0] {
		PIC_IDLE   = 3'b001,
		PIC_ACCEPT = 3'b010,
		PIC_WAIT   = 3'b100
	} pic_state_t;
endpackage

// ==== verilog/pic_prio_enc.sv ====
// pic_prio_enc: fixed-priority encoder, lowest index wins
// assumes a combinational request vector; no clock
`timescale 1ns/1ns
module pic_prio_enc #(
	parameter int N = 16
) (
	input  wire logic [N-1:0]         req,
	output logic                      any,
	output logic [$clog2(N)-1:0]      idx
);
	// scan from the top so the lowest index is the last to write
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = ($clog2(N))'(i);
			end
		end
	end
endmodule

// ==== verilog/pic_top.sv ====
// pic_top: prioritized vectored interrupt controller
// assumes a cpu core that pulses instr_last, accept_ack and the return strobes,
// and peripherals that pulse one request bit per event
`timescale 1ns/1ns
`include "pic_params.svh"
module pic_top
	import pic_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire pic_sfr_req_t sfr_req,
	output logic [7:0]        sfr_rdata,
	input  wire logic [15:2]  src_request,
	input  wire logic         software_trap,
	input  wire logic         ext0_pin_gate,
	input  wire logic         instr_last,
	input  wire logic         accept_ack,
	input  wire logic         maskable_return,
	input  wire logic         nonmaskable_return,
	output logic              irq_request,
	output logic [15:0]       irq_vector,
	output logic              accept_busy,
	output logic              nm_active
);
	logic [15:0] pending_latch_q;
	logic [15:0] enable_word_q;
	logic        nm_active_q;
	logic        nm_saved_mef_q;
	logic        trap_pending_q;
	logic [3:0]  sel_idx_q;
	logic [3:0]  cycle_q;
	pic_state_t  state_q;
	logic [15:0] eligible;
	logic        any_req;
	logic [3:0]  win_idx;
	logic        master_enable_flag;
	logic        take;
	logic        wr_pend_lo;
	logic        wr_pend_hi;
	logic        wr_en_lo;
	logic        wr_en_hi;

	assign master_enable_flag = enable_word_q[`PIC_MEF_BIT];
	assign wr_pend_lo = sfr_req.wr && sfr_req.addr == `PIC_ADDR_PENDING_LO;
	assign wr_pend_hi = sfr_req.wr && sfr_req.addr == `PIC_ADDR_PENDING_HI;
	assign wr_en_lo   = sfr_req.wr && sfr_req.addr == `PIC_ADDR_ENABLE_LO;
	assign wr_en_hi   = sfr_req.wr && sfr_req.addr == `PIC_ADDR_ENABLE_HI;

	// gating of each source: trap and watchdog ignore enables but never nest
	always_comb begin
		eligible = 16'h0000;
		eligible[`PIC_SRC_TRAP] = trap_pending_q && !nm_active_q;
		eligible[`PIC_SRC_WDT]  = pending_latch_q[`PIC_SRC_WDT] && !nm_active_q;
		eligible[`PIC_SRC_EXT0] = pending_latch_q[`PIC_SRC_EXT0] && master_enable_flag
			&& ext0_pin_gate;
		for (int i = `PIC_FIRST_GATED; i < 16; i++) begin
			eligible[i] = pending_latch_q[i] && enable_word_q[i] && master_enable_flag;
		end
	end

	pic_prio_enc #(
		.N (16)
	) u_prio (
		.req (eligible),
		.any (any_req),
		.idx (win_idx)
	);

	// sampling only at the end of an instruction keeps acceptance instruction-atomic
	assign take = state_q == PIC_IDLE && instr_last && any_req;

	// acceptance sequencer: request held to the core only until it acknowledges
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q   <= PIC_IDLE;
			sel_idx_q <= 4'h0;
			cycle_q   <= 4'h0;
		end else begin
			unique case (state_q)
				PIC_IDLE: begin
					if (take) begin
						state_q   <= PIC_ACCEPT;
						sel_idx_q <= win_idx;
						cycle_q   <= 4'h0;
					end
				end
				PIC_ACCEPT: begin
					if (accept_ack) begin
						state_q <= PIC_WAIT;
						cycle_q <= 4'h1;
					end
				end
				PIC_WAIT: begin
					// core pushes pc and status during these cycles, then loads vector
					if (cycle_q == `PIC_ACCEPT_CYCLES - 4'h1) begin
						state_q <= PIC_IDLE;
					end
					cycle_q <= cycle_q + 4'h1;
				end
				default: state_q <= PIC_IDLE;
			endcase
		end
	end

	assign irq_request = state_q == PIC_ACCEPT;
	assign accept_busy = state_q != PIC_IDLE;
	assign nm_active   = nm_active_q;

	// vector is registered so it is stable while the request is shown
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_vector <= `PIC_VECTOR_TOP;
		end else if (take) begin
			irq_vector <= `PIC_VECTOR_TOP - {11'h000, win_idx, 1'b0};
		end
	end

	// pending latches: hardware set wins over a software clear in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pending_latch_q <= `PIC_PENDING_RESET;
		end else begin
			for (int i = 2; i < 16; i++) begin
				if (src_request[i]) begin
					pending_latch_q[i] <= 1'b1;
				end else if (state_q == PIC_ACCEPT && accept_ack && sel_idx_q == 4'(i)) begin
					pending_latch_q[i] <= 1'b0;
				end else if (wr_pend_lo && i < 8 && !sfr_req.wdata[i % 8]) begin
					pending_latch_q[i] <= 1'b0;
				end else if (wr_pend_hi && i >= 8 && !sfr_req.wdata[i % 8]) begin
					pending_latch_q[i] <= 1'b0;
				end
			end
			pending_latch_q[1:0] <= 2'b00; // no latch for reset or the trap
		end
	end

	// trap is latched at once and taken at an instruction end; a trap during non-maskable service acts as a no-op
	// a new trap pulse wins over the acceptance clear; a pulse not taken at the next instruction end is lost
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trap_pending_q <= 1'b0;
		end else if (software_trap && !nm_active_q) begin
			trap_pending_q <= 1'b1;
		end else if (state_q == PIC_ACCEPT && accept_ack && sel_idx_q == `PIC_SRC_TRAP) begin
			trap_pending_q <= 1'b0;
		end else if (instr_last) begin
			trap_pending_q <= 1'b0;
		end
	end

	// enable word: writes, acceptance clear and return restores of master enable
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enable_word_q <= `PIC_ENABLE_RESET;
		end else begin
			if (wr_en_lo) begin
				enable_word_q[7:0] <= sfr_req.wdata;
			end
			if (wr_en_hi) begin
				enable_word_q[15:8] <= sfr_req.wdata;
			end
			enable_word_q[3:1] <= 3'b000; // unused bits read zero
			if (state_q == PIC_ACCEPT && accept_ack) begin
				enable_word_q[`PIC_MEF_BIT] <= 1'b0;
			end else if (maskable_return) begin
				enable_word_q[`PIC_MEF_BIT] <= 1'b1;
			end else if (nonmaskable_return) begin
				enable_word_q[`PIC_MEF_BIT] <= nm_saved_mef_q;
			end
		end
	end

	// non-maskable service tracking with saved master enable
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nm_active_q    <= 1'b0;
			nm_saved_mef_q <= 1'b0;
		end else if (state_q == PIC_ACCEPT && accept_ack
				&& (sel_idx_q == `PIC_SRC_TRAP || sel_idx_q == `PIC_SRC_WDT)) begin
			nm_active_q    <= 1'b1;
			nm_saved_mef_q <= master_enable_flag;
		end else if (nonmaskable_return) begin
			nm_active_q <= 1'b0;
		end
	end

	// register read data, one cycle after the read strobe
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				`PIC_ADDR_ENABLE_LO:  sfr_rdata <= enable_word_q[7:0];
				`PIC_ADDR_ENABLE_HI:  sfr_rdata <= enable_word_q[15:8];
				`PIC_ADDR_PENDING_LO: sfr_rdata <= pending_latch_q[7:0];
				`PIC_ADDR_PENDING_HI: sfr_rdata <= pending_latch_q[15:8];
				default:              sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule
